// file: bench/rgtc_props_properties.sv
/* rgtc_props: port-level checks of the timing configuration block.
   Assumes one mclk domain; bound from the bench top file. */
`timescale 1ns/100ps
module rgtc_props (
  input wire logic                    mclk,
  input wire logic                    sys_rst,
  input wire logic [3:0]              reg_addr,
  input wire logic [7:0]              reg_wdata,
  input wire logic                    reg_write,
  input wire logic                    reg_read,
  input wire logic [7:0]              reg_rdata,
  input wire rgtc_pkg::rgtc_current_t current_cfg,
  input wire rgtc_pkg::rgtc_events_t  events
);
  import rgtc_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic wr_cur;
  logic wr_rise;
  logic wr_fall;
  assign wr_cur  = reg_write && reg_addr == CURRENT_CTRL_ADDR;
  assign wr_rise = reg_write && reg_addr == RISE_SEL_ADDR;
  assign wr_fall = reg_write && reg_addr == FALL_SEL_ADDR;
  reset_clear_a: assert property ($past(sys_rst) |-> current_cfg == '0 && events == '0)
    else $error("state not clear after reset");
  read_idle_a: assert property (!$past(reg_read) |-> reg_rdata == '0)
    else $error("read data outside its slot");
  cur_write_a: assert property (wr_cur |=>
    current_cfg == {$past(reg_wdata[7]), $past(reg_wdata[4:0])}) else $error("current bad");
  cur_hold_a: assert property (!wr_cur |=> $stable(current_cfg))
    else $error("current changed without write");
  cur_gap_a: assert property ((reg_read && reg_addr == CURRENT_CTRL_ADDR) |=>
    reg_rdata[6:5] == '0) else $error("current gap bits set");
  rise_upper_a: assert property ((reg_read && reg_addr == RISE_SEL_ADDR) |=>
    reg_rdata[7:4] == '0) else $error("rise selector upper bits set");
  fall_back_a: assert property (wr_fall ##1 (reg_read && reg_addr == FALL_SEL_ADDR) |=>
    reg_rdata == {4'h0, $past(reg_wdata[3:0], 2)}) else $error("fall selector readback");
  rise_rsvd_a: assert property ((wr_rise && reg_wdata[3:0] > SRC_CCP_LAST) ##1 !wr_rise [*2]
    |-> !events.rise_level) else $error("reserved rise code active");
  cover property (wr_rise && reg_wdata[3:0] == SRC_PIN);
  cover property (events.rise_pulse ##1 !events.rise_pulse);
  cover property (reg_read && reg_addr > STATUS_ADDR);
endmodule

// file: bench/rgtc_src_model.sv
/* rgtc_src_model: comparator, pwm, capture and pin outputs seen by the block.
   Assumes the bench supplies the next values; all relaunched on mclk. */
`timescale 1ns/100ps
module rgtc_src_model (
  input  wire logic                    mclk,
  input  wire rgtc_pkg::rgtc_sources_t nsrc,
  input  wire logic [31:0]             npins,
  output rgtc_pkg::rgtc_sources_t      sources = '0,
  output logic [31:0]                  pins = '0
);
  import rgtc_pkg::*;
  // flop launch: on-chip sources change only on mclk, like the real peripherals
  always @(posedge mclk) begin
    sources <= nsrc;
    pins <= npins;
  end
endmodule

// file: bench/tb_ramp_generator_timing_config.sv
/* tb top: corner and random register traffic, source selection and edge checks.
   Assumes the rtl package; the partner model drives sources and pins. */
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb_ramp_generator_timing_config;
  import rgtc_pkg::*;
  logic          mclk = 0, sys_rst = 1, reg_write = 0, reg_read = 0;
  logic [3:0]    reg_addr = '0;
  logic [7:0]    reg_wdata = '0, reg_rdata;
  logic [31:0]   pins, npins = '0, seed = 32'h8F6D4147;
  rgtc_sources_t sources, nsrc = '0;
  rgtc_current_t current_cfg;
  rgtc_events_t  events;
  int            num_errors = 0, n_checks = 0, cnt, cntf;
  always #5 mclk = ~mclk;
  rgtc_timing_config #(.PIN_COUNT(32)) dut (.mclk, .sys_rst, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .sources, .dedicated_timing_pin(pins),
    .current_cfg, .events);
  rgtc_src_model part (.mclk, .nsrc, .npins, .sources, .pins);
  function automatic logic [31:0] rnd(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] reg_mask(input logic [3:0] a);
    case (a)
      CURRENT_CTRL_ADDR: return 8'h9F;
      RISE_SEL_ADDR, FALL_SEL_ADDR: return 8'h0F;
      EVENT_CTRL_ADDR: return 8'h33;
      RISE_PIN_ADDR, FALL_PIN_ADDR: return 8'h1F;
      default: return 8'h00;
    endcase
  endfunction
  function automatic logic pick(input logic [3:0] c, input rgtc_sources_t s,
                                input logic [31:0] p, input logic [4:0] r, input logic pol);
    if (c > SRC_CCP_LAST) return 1'b0;
    if (c == SRC_PIN) return p[r] ^ pol;
    if (c < SRC_PIN) return s.synced_comparator_out[c[1:0]] ^ pol;
    if (c < SRC_CCP_FIRST) return s.pulse_width_out[2'(c - SRC_PWM_FIRST)] ^ pol;
    return s.capture_compare_out[~c[0]] ^ pol;
  endfunction
  // strobe left high: back-to-back writes must not assign it twice in one step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
  endtask
  // checks at the falling edge so the registered answer has settled
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    reg_write <= 1'b0;
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_read <= 1'b0;
    @(negedge mclk);
    `CHK("reg_rdata", e, reg_rdata)
    @(posedge mclk);
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #50000;
    num_errors++;
    report_and_stop();
  end
  initial begin
    logic [3:0] a;
    logic [7:0] d;
    logic       er, ef;
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    `CHK("current_cfg", 6'h00, current_cfg)
    for (int i = 0; i < 16; i++) rd(4'(i), 8'h00);
    // first pass writes all ones to indices 0-7, status included, then random
    for (int i = 0; i < 32; i++) begin
      seed = rnd(seed);
      a = (i < 8) ? 4'(i) : seed[3:0];
      d = (i < 8) ? 8'hFF : seed[15:8];
      if (i < 8 || a != STATUS_ADDR) begin
        wr(a, d);
        rd(a, d & reg_mask(a));
        if (a == CURRENT_CTRL_ADDR) `CHK("current_cfg", {d[7], d[4:0]}, current_cfg)
      end
    end
    // fall code runs opposite to rise code to show the two are independent
    for (int c = 0; c < 16; c++) begin
      seed = rnd(seed);
      wr(RISE_SEL_ADDR, 8'(c));
      wr(FALL_SEL_ADDR, 8'(15 - c));
      wr(EVENT_CTRL_ADDR, {6'h00, seed[1:0]});
      wr(RISE_PIN_ADDR, {3'h0, seed[6:2]});
      wr(FALL_PIN_ADDR, {3'h0, seed[11:7]});
      reg_write <= 1'b0;
      nsrc <= seed[21:12];
      npins <= rnd(seed);
      repeat (6) @(posedge mclk);
      @(negedge mclk);
      er = pick(4'(c), nsrc, npins, seed[6:2], seed[0]);
      ef = pick(4'(15 - c), nsrc, npins, seed[11:7], seed[1]);
      `CHK("rise_level", er, events.rise_level)
      `CHK("fall_level", ef, events.fall_level)
      `CHK("rise_pulse", er, events.rise_pulse)
      `CHK("fall_pulse", ef, events.fall_pulse)
      @(posedge mclk);
      rd(STATUS_ADDR, {6'h00, ef, er});
    end
    for (int p = 0; p < 2; p++) begin
      // both inputs on comparator 1, edge mode, polarity follows p
      wr(RISE_SEL_ADDR, 8'h00);
      wr(FALL_SEL_ADDR, 8'h00);
      wr(EVENT_CTRL_ADDR, 8'h30 | 8'(3 * p));
      reg_write <= 1'b0;
      nsrc <= 10'(p) << 6;
      repeat (4) @(posedge mclk);
      nsrc <= 10'(1 - p) << 6;
      cnt = 0;
      cntf = 0;
      repeat (8) begin
        @(negedge mclk);
        cnt += events.rise_pulse;
        cntf += events.fall_pulse;
      end
      `CHK("edge_pulses", 1, cnt)
      `CHK("fall_pulses", 1, cntf)
      `CHK("rise_level", 1'b1, events.rise_level)
      `CHK("fall_level", 1'b1, events.fall_level)
      @(posedge mclk);
    end
    // mid-run reset must clear everything again, not only power-on
    wr(CURRENT_CTRL_ADDR, 8'h9F);
    reg_write <= 1'b0;
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    `CHK("current_cfg", 6'h00, current_cfg)
    for (int i = 0; i < 8; i++) rd(4'(i), 8'h00);
    report_and_stop();
  end
endmodule
bind rgtc_timing_config rgtc_props props (.mclk, .sys_rst, .reg_addr, .reg_wdata, .reg_write,
  .reg_read, .reg_rdata, .current_cfg, .events);

// file: rtl/rgtc_pkg.sv
/*
  rgtc_pkg: register indices, field positions, reset values, timing source
  codes and carrier structs for the ramp generator timing configuration.
  Assumes an 8-bit register port with 4-bit word addresses.
*/
package rgtc_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // register indices on the plain register port
  localparam logic [ADDR_W-1:0] CURRENT_CTRL_ADDR = 4'h0;
  localparam logic [ADDR_W-1:0] RISE_SEL_ADDR     = 4'h1;
  localparam logic [ADDR_W-1:0] FALL_SEL_ADDR     = 4'h2;
  localparam logic [ADDR_W-1:0] EVENT_CTRL_ADDR   = 4'h3;
  localparam logic [ADDR_W-1:0] RISE_PIN_ADDR     = 4'h4;
  localparam logic [ADDR_W-1:0] FALL_PIN_ADDR     = 4'h5;
  localparam logic [ADDR_W-1:0] STATUS_ADDR       = 4'h6;

  // ramp_current_control fields
  localparam int LOW_RANGE_BIT   = 7;
  localparam int STEP_CODE_MSB   = 4;
  localparam int STEP_CODE_W     = 5;

  // source selector field
  localparam int SOURCE_CODE_W   = 4;

  // event control fields (own register)
  localparam int RISE_ACT_LOW_BIT = 0;
  localparam int FALL_ACT_LOW_BIT = 1;
  localparam int RISE_EDGE_BIT    = 4;
  localparam int FALL_EDGE_BIT    = 5;

  // pin route field width
  localparam int PIN_ROUTE_W     = 5;

  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;

  // timing source codes
  localparam logic [SOURCE_CODE_W-1:0] SRC_COMP_FIRST  = 4'h0;
  localparam logic [SOURCE_CODE_W-1:0] SRC_COMP_LAST   = 4'h3;
  localparam logic [SOURCE_CODE_W-1:0] SRC_PIN         = 4'h4;
  localparam logic [SOURCE_CODE_W-1:0] SRC_PWM_FIRST   = 4'h5;
  localparam logic [SOURCE_CODE_W-1:0] SRC_PWM_LAST    = 4'h8;
  localparam logic [SOURCE_CODE_W-1:0] SRC_CCP_FIRST   = 4'h9;
  localparam logic [SOURCE_CODE_W-1:0] SRC_CCP_LAST    = 4'hA;

  // on-chip timing signals, all on mclk already
  typedef struct packed {
    logic [3:0] synced_comparator_out;  // comparators 1..4
    logic [3:0] pulse_width_out;        // pwm 3..6
    logic [1:0] capture_compare_out;    // ccp 1..2
  } rgtc_sources_t;

  // configuration handed to the ramp core
  typedef struct packed {
    logic                    low_range_enable;
    logic [STEP_CODE_W-1:0]  current_step_code;
  } rgtc_current_t;

  // conditioned timing events for the ramp core
  typedef struct packed {
    logic rise_level;
    logic rise_pulse;
    logic fall_level;
    logic fall_pulse;
  } rgtc_events_t;

endpackage

// file: rtl/rgtc_timing_config.sv
/*
  rgtc_timing_config: register bank holding the current step setting and
  the rise/fall timing source selectors, plus the source multiplexers,
  polarity and edge/level conditioning for the ramp core.
  Assumes on-chip sources are on mclk; pins are asynchronous and are
  synchronised here before any use.
*/
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/100ps
// Functional notes
// - current control holds low range at bit 7, step code bits 4-0, 6-5 zero.
// - step code 0h-1Fh steps ramp current; low range selects the small scale.
// - four-bit rise selector picks the rising timing source, bits 3-0.
// - separate four-bit fall selector, same code table, independent of rise.
// - codes 0-3 comparators, 4 pin, 5-8 pwm 3-6, 9-A ccp, B-F reserved.
// - pin code takes the pin chosen by the rise or fall pin route.
// - selector bits 7-4 ignore writes and read zero.
// - all implemented bits reset to zero on any reset.
// - polarity bit per input makes the selected signal active low.
// - mode bit per input makes the pulse output edge-detected when set, level when clear.
module rgtc_timing_config #(
  parameter int PIN_COUNT = 32
) (
  input  wire logic                                 mclk,
  input  wire logic                                 sys_rst,
  input  wire logic [rgtc_pkg::ADDR_W-1:0]          reg_addr,
  input  wire logic [rgtc_pkg::DATA_W-1:0]          reg_wdata,
  input  wire logic                                 reg_write,
  input  wire logic                                 reg_read,
  output logic      [rgtc_pkg::DATA_W-1:0]          reg_rdata,
  input  wire rgtc_pkg::rgtc_sources_t              sources,
  input  wire logic [PIN_COUNT-1:0]                 dedicated_timing_pin,
  output rgtc_pkg::rgtc_current_t                   current_cfg,
  output rgtc_pkg::rgtc_events_t                    events
);
  import rgtc_pkg::*;

  logic                     low_range_enable_reg;
  logic [STEP_CODE_W-1:0]   current_step_code_reg;
  logic [SOURCE_CODE_W-1:0] rise_event_source_code_reg;
  logic [SOURCE_CODE_W-1:0] fall_event_source_code_reg;
  logic                     rise_active_low_reg;
  logic                     fall_active_low_reg;
  logic                     rise_edge_mode_reg;
  logic                     fall_edge_mode_reg;
  logic [PIN_ROUTE_W-1:0]   rise_pin_route_reg;
  logic [PIN_ROUTE_W-1:0]   fall_pin_route_reg;
  logic [PIN_COUNT-1:0]     pin_meta_reg;
  logic [PIN_COUNT-1:0]     pin_sync_reg;
  logic [1:0]               active_reg;
  logic [1:0]               event_pulse_reg;
  logic [1:0]               event_level_reg;
  logic [DATA_W-1:0]        rdata_next;
  logic [1:0]               raw_sel;
  logic [1:0]               active_next;

  // register writes
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      low_range_enable_reg  <= 1'b0;
      current_step_code_reg <= '0;
    end else if (reg_write && reg_addr == CURRENT_CTRL_ADDR) begin
      low_range_enable_reg  <= reg_wdata[LOW_RANGE_BIT];
      current_step_code_reg <= reg_wdata[STEP_CODE_MSB:0];
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rise_event_source_code_reg <= '0;
    end else if (reg_write && reg_addr == RISE_SEL_ADDR) begin
      rise_event_source_code_reg <= reg_wdata[SOURCE_CODE_W-1:0];
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      fall_event_source_code_reg <= '0;
    end else if (reg_write && reg_addr == FALL_SEL_ADDR) begin
      fall_event_source_code_reg <= reg_wdata[SOURCE_CODE_W-1:0];
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rise_active_low_reg <= 1'b0;
      fall_active_low_reg <= 1'b0;
      rise_edge_mode_reg  <= 1'b0;
      fall_edge_mode_reg  <= 1'b0;
    end else if (reg_write && reg_addr == EVENT_CTRL_ADDR) begin
      rise_active_low_reg <= reg_wdata[RISE_ACT_LOW_BIT];
      fall_active_low_reg <= reg_wdata[FALL_ACT_LOW_BIT];
      rise_edge_mode_reg  <= reg_wdata[RISE_EDGE_BIT];
      fall_edge_mode_reg  <= reg_wdata[FALL_EDGE_BIT];
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rise_pin_route_reg <= '0;
      fall_pin_route_reg <= '0;
    end else if (reg_write) begin
      if (reg_addr == RISE_PIN_ADDR) begin
        rise_pin_route_reg <= reg_wdata[PIN_ROUTE_W-1:0];
      end
      if (reg_addr == FALL_PIN_ADDR) begin
        fall_pin_route_reg <= reg_wdata[PIN_ROUTE_W-1:0];
      end
    end
  end

  // read mux; unmapped indices read zero
  always_comb begin
    rdata_next = '0;
    unique case (reg_addr)
      CURRENT_CTRL_ADDR: begin
        rdata_next[LOW_RANGE_BIT]     = low_range_enable_reg;
        rdata_next[STEP_CODE_MSB:0]   = current_step_code_reg;
      end
      RISE_SEL_ADDR: rdata_next[SOURCE_CODE_W-1:0] = rise_event_source_code_reg;
      FALL_SEL_ADDR: rdata_next[SOURCE_CODE_W-1:0] = fall_event_source_code_reg;
      EVENT_CTRL_ADDR: begin
        rdata_next[RISE_ACT_LOW_BIT] = rise_active_low_reg;
        rdata_next[FALL_ACT_LOW_BIT] = fall_active_low_reg;
        rdata_next[RISE_EDGE_BIT]    = rise_edge_mode_reg;
        rdata_next[FALL_EDGE_BIT]    = fall_edge_mode_reg;
      end
      RISE_PIN_ADDR: rdata_next[PIN_ROUTE_W-1:0] = rise_pin_route_reg;
      FALL_PIN_ADDR: rdata_next[PIN_ROUTE_W-1:0] = fall_pin_route_reg;
      STATUS_ADDR: rdata_next[1:0] = event_level_reg;
      default: rdata_next = '0;
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= '0;
    end else if (reg_read) begin
      reg_rdata <= rdata_next;
    end else begin
      reg_rdata <= '0;
    end
  end

  // the core's analog current source decodes this code
  assign current_cfg.low_range_enable  = low_range_enable_reg;
  assign current_cfg.current_step_code = current_step_code_reg;

  // pins are asynchronous: two flops before the mux looks at them
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
    end else begin
      pin_meta_reg <= dedicated_timing_pin;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  function automatic logic pick_source(input logic [SOURCE_CODE_W-1:0] code,
                                       input logic [PIN_ROUTE_W-1:0]   route,
                                       input rgtc_sources_t           src,
                                       input logic [PIN_COUNT-1:0]    pins);
    logic sel;
    sel = 1'b0;
    if (code <= SRC_COMP_LAST) begin
      sel = src.synced_comparator_out[code[1:0]];
    end else if (code == SRC_PIN) begin
      sel = (32'(route) < PIN_COUNT) ? pins[route] : 1'b0;
    end else if (code <= SRC_PWM_LAST) begin
      sel = src.pulse_width_out[2'(code - SRC_PWM_FIRST)];
    end else if (code <= SRC_CCP_LAST) begin
      sel = src.capture_compare_out[1'(code - SRC_CCP_FIRST)];
    end
    return sel;
  endfunction

  // polarity applied after selection; reserved codes stay inactive whatever
  // the polarity so that no spurious event appears
  always_comb begin
    raw_sel[0] = pick_source(rise_event_source_code_reg, rise_pin_route_reg,
                             sources, pin_sync_reg);
    raw_sel[1] = pick_source(fall_event_source_code_reg, fall_pin_route_reg,
                             sources, pin_sync_reg);
    active_next[0] = (rise_event_source_code_reg > SRC_CCP_LAST) ? 1'b0
                     : raw_sel[0] ^ rise_active_low_reg;
    active_next[1] = (fall_event_source_code_reg > SRC_CCP_LAST) ? 1'b0
                     : raw_sel[1] ^ fall_active_low_reg;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      active_reg <= '0;
    end else begin
      active_reg <= active_next;
    end
  end

  // edge mode: one pulse on the active-going transition; level mode: follows
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      event_pulse_reg <= '0;
      event_level_reg <= '0;
    end else begin
      event_level_reg <= active_next;
      event_pulse_reg[0] <= rise_edge_mode_reg ? (active_next[0] & ~active_reg[0])
                                               : active_next[0];
      event_pulse_reg[1] <= fall_edge_mode_reg ? (active_next[1] & ~active_reg[1])
                                               : active_next[1];
    end
  end

  assign events.rise_level = event_level_reg[0];
  assign events.rise_pulse = event_pulse_reg[0];
  assign events.fall_level = event_level_reg[1];
  assign events.fall_pulse = event_pulse_reg[1];

endmodule
